// File: verilog/lin_xcvr_map.svh
`ifndef LIN_XCVR_MAP_SVH
`define LIN_XCVR_MAP_SVH

// reference clock
`define CLK_PERIOD_NS 100

// enabling time, least time: rounded up
`define EN_TIME_NS 15000
`define EN_CYC ((`EN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// bus wake filter time (dominant must last longer than this)
`define WAKE_FILT_NS 100000
`define WAKE_FILT_CYC ((`WAKE_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// transmit and bus dominant time-outs
`define TX_TO_NS 300000
`define TX_TO_CYC (`TX_TO_NS / `CLK_PERIOD_NS)
`define BUS_TO_NS 300000
`define BUS_TO_CYC (`BUS_TO_NS / `CLK_PERIOD_NS)

// transceiver mode codes, two bits wide
`define CODE_OFF 2'h0
`define CODE_WAKE 2'h1
`define CODE_RXONLY 2'h2
`define CODE_NORMAL 2'h3

// command buffer and counter sizes
`define CMD_FIFO_DEPTH 4
`define CNT_WIDTH 12

`endif

// File: verilog/lin_xcvr_pkg.sv
package lin_xcvr_pkg;

    // device operating modes, driven by the device state machine
    typedef enum logic [2:0] {
        DEV_NORMAL   = 3'b000,
        DEV_STOP     = 3'b001,
        DEV_SLEEP    = 3'b010,
        DEV_RESTART  = 3'b011,
        DEV_FAILSAFE = 3'b100
    } dev_mode_e;

    // transceiver states; woken reads back as the wake-capable code
    typedef enum logic [2:0] {
        XS_OFF    = 3'b000,
        XS_NORMAL = 3'b001,
        XS_RXONLY = 3'b010,
        XS_WAKE   = 3'b011,
        XS_WOKEN  = 3'b100
    } xcvr_state_e;

    // one mode selection written by the host
    typedef struct packed {
        logic [1:0] code;
    } mode_cmd_s;

    typedef logic [11:0] cnt_t;

endpackage

// File: verilog/lin_mode_wake.sv
// Behaviour
// - power-up in off; off always selectable
// - off mode ignores bus wake activity
// - host selects mode via mode bits
// - normal mode only in Normal/Stop
// - bus follows transmit input in normal
// - early dominant suppressed until input returns high
// - received level shown on receive output
// - receive-only: driver off, reception on
// - wake mode by command; auto in Fail-Safe
// - long dominant then release detects wake
// - wake holds receive low until mode change
// - wake outcome depends on device mode
// - mode bits keep wake code after wake
// - rearm on entering Stop, Sleep, Fail-Safe
// - transmit time-out disables driver, flags fault
// - bus dominant time-out flags fault
`include "lin_xcvr_map.svh"
`timescale 1ns/10ps
`default_nettype none

// small synchronous fifo; depth must be a power of two so pointers wrap
module cmd_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output var logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push;
    logic pop;

    // ready is registered so the source sees a clean flop
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    // storage
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers, fill level and ready
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule

module lin_mode_wake
    import lin_xcvr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // host mode commands
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire mode_cmd_s cmd_data,
    output logic [1:0] mode_rdata,
    // device operating mode and link fault flag
    input wire dev_mode_e dev_mode,
    output logic link_fault,
    input wire logic link_fault_clr,
    output logic restart_req,
    // host pins
    input wire logic bus_tx_input,
    output logic bus_rx_output,
    output logic host_irq_n,
    // bus pin, open drain: driven low while enabled
    input wire logic bus_level_i,
    output logic bus_drv_o,
    output logic bus_drv_oe
);
    localparam int EN_N = `EN_CYC;
    localparam int WK_N = `WAKE_FILT_CYC;
    localparam int TXTO_N = `TX_TO_CYC;
    localparam int BUSTO_N = `BUS_TO_CYC;

    // saturating counter step
    function automatic cnt_t sat_inc(input cnt_t c);
        return (c == '1) ? c : c + 1'b1;
    endfunction

    // mode code shown for a state; woken keeps the wake code
    function automatic logic [1:0] state_code(input xcvr_state_e s);
        logic [1:0] c;
        c = `CODE_OFF;
        unique case (s)
            XS_OFF: c = `CODE_OFF;
            XS_NORMAL: c = `CODE_NORMAL;
            XS_RXONLY: c = `CODE_RXONLY;
            XS_WAKE, XS_WOKEN: c = `CODE_WAKE;
            default: c = `CODE_OFF;
        endcase
        return c;
    endfunction

    // state after a host command; illegal selections leave state alone
    function automatic xcvr_state_e apply_cmd(input logic [1:0] code, input dev_mode_e dm, input xcvr_state_e s);
        logic rx_ok;
        xcvr_state_e n;
        rx_ok = (dm == DEV_NORMAL) || (dm == DEV_STOP);
        n = s;
        unique case (code)
            `CODE_OFF: n = XS_OFF;
            `CODE_NORMAL: n = rx_ok ? XS_NORMAL : s;
            `CODE_RXONLY: n = rx_ok ? XS_RXONLY : s;
            `CODE_WAKE: n = (s == XS_WOKEN || dm == DEV_FAILSAFE) ? s : XS_WAKE;
        endcase
        return n;
    endfunction

    xcvr_state_e state_r;
    xcvr_state_e state_q_r;
    dev_mode_e dev_q_r;
    logic tx_s1_r;
    logic tx_s_r;
    logic bus_s1_r;
    logic bus_s_r;
    logic bus_q_r;
    cnt_t en_cnt_r;
    cnt_t tx_cnt_r;
    cnt_t dom_cnt_r;
    logic tx_block_r;
    logic wk_edge_r;
    logic woke_local_r;
    logic fifo_valid;
    mode_cmd_s fifo_data;
    logic en_busy;
    logic cmd_pop;
    logic dev_chg;
    logic tx_to;
    logic bus_to;
    logic wake_hit;
    logic rx_mode;

    // commands queue here while the enabling time runs
    cmd_fifo #(.WIDTH($bits(mode_cmd_s)), .DEPTH(`CMD_FIFO_DEPTH)) u_cmd_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_data),
        .out_valid(fifo_valid),
        .out_ready(cmd_pop),
        .out_data(fifo_data)
    );

    // pin synchronisers; the second stage is read, plus a third bus stage for edge detection
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_s1_r <= 1'b1;
            tx_s_r <= 1'b1;
            bus_s1_r <= 1'b1;
            bus_s_r <= 1'b1;
            bus_q_r <= 1'b1;
        end else begin
            tx_s1_r <= bus_tx_input;
            tx_s_r <= tx_s1_r;
            bus_s1_r <= bus_level_i;
            bus_s_r <= bus_s1_r;
            bus_q_r <= bus_s_r;
        end
    end

    // decode of the current situation
    assign dev_chg = (dev_mode != dev_q_r);
    assign rx_mode = (state_r == XS_NORMAL) || (state_r == XS_RXONLY);
    assign en_busy = (state_r == XS_NORMAL) && ((state_q_r != XS_NORMAL) || (en_cnt_r != '0));
    assign cmd_pop = fifo_valid && !en_busy && !dev_chg;
    assign tx_to = (tx_cnt_r > cnt_t'(TXTO_N));
    assign bus_to = rx_mode && (dom_cnt_r > cnt_t'(BUSTO_N));
    // release after a long dominant phase, off mode never gets here
    assign wake_hit = (state_r == XS_WAKE) && wk_edge_r && bus_s_r && !bus_q_r
        && (dom_cnt_r > cnt_t'(WK_N));

    // transceiver mode; device mode changes take priority over commands
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= XS_OFF;
        end else if (dev_chg && dev_mode == DEV_FAILSAFE) begin
            state_r <= XS_WAKE;
        end else if (dev_chg && state_r == XS_WOKEN && (dev_mode == DEV_STOP || dev_mode == DEV_SLEEP)) begin
            state_r <= XS_WAKE;
        end else if (dev_chg && rx_mode && dev_mode != DEV_NORMAL && dev_mode != DEV_STOP) begin
            state_r <= XS_WAKE;
        end else if (cmd_pop) begin
            state_r <= apply_cmd(fifo_data.code, dev_mode, state_r);
        end else if (wake_hit) begin
            state_r <= XS_WOKEN;
        end
    end

    // history of state and device mode for edge decisions
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q_r <= XS_OFF;
            dev_q_r <= DEV_NORMAL;
        end else begin
            state_q_r <= state_r;
            dev_q_r <= dev_mode;
        end
    end

    // enabling time and suppression of an early dominant level
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_cnt_r <= '0;
            tx_block_r <= 1'b0;
        end else if (state_r != XS_NORMAL) begin
            en_cnt_r <= '0;
            tx_block_r <= 1'b0;
        end else if (state_q_r != XS_NORMAL) begin
            en_cnt_r <= cnt_t'(EN_N);
            tx_block_r <= 1'b1;
        end else begin
            if (en_cnt_r != '0) begin
                en_cnt_r <= en_cnt_r - 1'b1;
            end
            // a low input must go high before the next dominant bit counts
            if (en_cnt_r == '0 && tx_s_r) begin
                tx_block_r <= 1'b0;
            end
        end
    end

    // dominant-length counters for input time-out, bus time-out and wake filter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_cnt_r <= '0;
            dom_cnt_r <= '0;
        end else begin
            tx_cnt_r <= tx_s_r ? '0 : sat_inc(tx_cnt_r);
            dom_cnt_r <= bus_s_r ? '0 : sat_inc(dom_cnt_r);
        end
    end

    // wake needs a fresh recessive-to-dominant edge seen in wake mode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wk_edge_r <= 1'b0;
        end else if (state_r != XS_WAKE) begin
            wk_edge_r <= 1'b0;
        end else if (!bus_s_r && bus_q_r) begin
            wk_edge_r <= 1'b1;
        end
    end

    // open-drain driver: pull low only for a permitted dominant bit
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_drv_o <= 1'b0;
            bus_drv_oe <= 1'b0;
        end else begin
            bus_drv_o <= 1'b0;
            bus_drv_oe <= (state_r == XS_NORMAL) && !en_busy && !tx_block_r && !tx_to && !tx_s_r;
        end
    end

    // receive output and mode readback
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rx_output <= 1'b1;
            mode_rdata <= `CODE_OFF;
        end else begin
            bus_rx_output <= rx_mode ? bus_s_r : (state_r != XS_WOKEN);
            mode_rdata <= state_code(state_r);
        end
    end

    // wake outcome toward the host and the device state machine
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            woke_local_r <= 1'b0;
            host_irq_n <= 1'b1;
            restart_req <= 1'b0;
        end else begin
            restart_req <= 1'b0;
            if (wake_hit) begin
                woke_local_r <= (dev_mode == DEV_NORMAL) || (dev_mode == DEV_STOP);
                host_irq_n <= !((dev_mode == DEV_NORMAL) || (dev_mode == DEV_STOP));
                restart_req <= !((dev_mode == DEV_NORMAL) || (dev_mode == DEV_STOP));
            end else if (state_r != XS_WOKEN) begin
                host_irq_n <= 1'b1;
            end
        end
    end

    // link fault flag; a new fault wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_fault <= 1'b0;
        end else if (tx_to || bus_to) begin
            link_fault <= 1'b1;
        end else if (link_fault_clr) begin
            link_fault <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_enable_early_low;
        (state_r == XS_NORMAL && state_q_r != XS_NORMAL && !tx_s_r);
    endsequence

    sequence s_wake_release;
        (state_r == XS_WAKE && wk_edge_r && bus_s_r && !bus_q_r && dom_cnt_r > cnt_t'(WK_N) && !dev_chg && !cmd_pop);
    endsequence

    a_reset_to_off: assert property ($fell(sys_rst) |-> state_r == XS_OFF)
        else $error("transceiver not off after reset");
    a_off_no_wake: assert property (state_r == XS_OFF |=> state_r != XS_WOKEN && bus_rx_output)
        else $error("wake reported in off mode");
    a_illegal_normal_held: assert property (cmd_pop && fifo_data.code == `CODE_NORMAL
        && dev_mode != DEV_NORMAL && dev_mode != DEV_STOP |=> state_r == $past(state_r))
        else $error("normal mode taken in wrong device mode");
    a_drive_follows_tx: assert property (bus_drv_oe |-> $past(!tx_s_r) && $past(state_r) == XS_NORMAL)
        else $error("bus driven without dominant input in normal mode");
    a_early_low_blocked: assert property (s_enable_early_low |=> !bus_drv_oe [*8])
        else $error("dominant sent during enabling time");
    a_rx_only_quiet: assert property (state_r == XS_RXONLY |=> !bus_drv_oe && bus_rx_output == $past(bus_s_r))
        else $error("receive-only mode drove bus or lost reception");
    a_failsafe_wake: assert property (dev_chg && dev_mode == DEV_FAILSAFE |=> state_r == XS_WAKE)
        else $error("fail-safe entry did not select wake mode");
    a_wake_detect: assert property (s_wake_release |=> state_r == XS_WOKEN)
        else $error("wake not detected after long dominant");
    a_woken_rx_low: assert property (state_r == XS_WOKEN |=> !bus_rx_output && mode_rdata == `CODE_WAKE)
        else $error("woken state without low receive output");
    a_wake_outcome: assert property (wake_hit |=> (woke_local_r && !host_irq_n && !restart_req)
        or (!woke_local_r && host_irq_n && restart_req ##1 !restart_req))
        else $error("wake outcome wrong for device mode");
    a_rearm_sleep: assert property (dev_chg && dev_mode == DEV_SLEEP && state_r == XS_WOKEN |=> state_r == XS_WAKE)
        else $error("wake not rearmed on sleep entry");
    a_tx_timeout: assert property (tx_to |=> !bus_drv_oe && link_fault)
        else $error("transmit time-out not handled");
    a_bus_timeout: assert property (bus_to && !dev_chg && !cmd_pop |=> link_fault && rx_mode)
        else $error("bus time-out did not flag fault");
endmodule

`default_nettype wire

// File: tb/lin_bus_node.sv
`timescale 1ns/10ps
`default_nettype none

// far side of the wire: pull-up resistor plus one remote node
module lin_bus_node (
    // clock
    input wire logic ref_clk,
    // device output stage
    input wire logic bus_drv_o,
    input wire logic bus_drv_oe,
    // resolved wire level
    output logic bus_level
);
    logic remote_dom_r = 1'b0;

    // wired-and: any driver pulls low, the pull-up gives recessive once all let go
    assign bus_level = (bus_drv_oe ? bus_drv_o : 1'b1) & ~remote_dom_r;

    // remote node holds the wire dominant for a number of cycles, then releases it
    task automatic send_dominant(input int cycles);
        @(posedge ref_clk);
        remote_dom_r <= 1'b1;
        repeat (cycles) @(posedge ref_clk);
        remote_dom_r <= 1'b0;
    endtask
endmodule

`default_nettype wire

// File: tb/lin_mode_wake_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module lin_mode_wake_tb_top
    import lin_xcvr_pkg::*;
;
    typedef struct packed {
        logic [2:0] sel;
        logic [1:0] exp;
    } note_s;

    localparam int s_mode = 0;
    localparam int s_rx = 1;
    localparam int s_irq = 2;
    localparam int s_oe = 3;
    localparam int s_fault = 4;
    localparam int s_rst = 5;
    localparam int s_rdy = 6;

    logic ref_clk;
    logic sys_rst;
    logic cmd_valid;
    logic cmd_ready;
    mode_cmd_s cmd_data;
    logic [1:0] mode_rdata;
    dev_mode_e dev_mode;
    logic link_fault;
    logic link_fault_clr;
    logic restart_req;
    logic bus_tx_input;
    logic bus_rx_output;
    logic host_irq_n;
    logic bus_level;
    logic bus_drv_o;
    logic bus_drv_oe;
    logic [1:0] restart_cnt;
    note_s notes[$];
    note_s nt;
    int fails;
    int compares;
    int cyc;
    int n;

    lin_mode_wake uut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready),
        .cmd_data(cmd_data),
        .mode_rdata(mode_rdata),
        .dev_mode(dev_mode),
        .link_fault(link_fault),
        .link_fault_clr(link_fault_clr),
        .restart_req(restart_req),
        .bus_tx_input(bus_tx_input),
        .bus_rx_output(bus_rx_output),
        .host_irq_n(host_irq_n),
        .bus_level_i(bus_level),
        .bus_drv_o(bus_drv_o),
        .bus_drv_oe(bus_drv_oe)
    );

    lin_bus_node node (
        .ref_clk(ref_clk),
        .bus_drv_o(bus_drv_o),
        .bus_drv_oe(bus_drv_oe),
        .bus_level(bus_level)
    );

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // restart request is a one-cycle pulse, so count pulses instead of sampling
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (restart_req === 1'b1) begin
            restart_cnt <= restart_cnt + 2'h1;
        end
        if (cyc == 30000) begin
            fails++;
            complete_run();
        end
    end

    task automatic cmp_bit(input string name, input logic exp, input logic seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cmp_code(input string name, input logic [1:0] exp, input logic [1:0] seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // monitor: outputs are settled at the falling edge, take notes oldest first
    always @(negedge ref_clk) begin
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.sel)
                3'h0: cmp_code("mode_rdata", nt.exp, mode_rdata);
                3'h1: cmp_bit("bus_rx_output", nt.exp[0], bus_rx_output);
                3'h2: cmp_bit("host_irq_n", nt.exp[0], host_irq_n);
                3'h3: cmp_bit("bus_drv_oe", nt.exp[0], bus_drv_oe);
                3'h4: cmp_bit("link_fault", nt.exp[0], link_fault);
                3'h6: cmp_bit("cmd_ready", nt.exp[0], cmd_ready);
                default: cmp_code("restart_count", nt.exp, restart_cnt);
            endcase
        end
    end

    task automatic note(input int sel, input logic [1:0] exp);
        note_s e;
        e.sel = sel[2:0];
        e.exp = exp;
        notes.push_back(e);
    endtask

    // valid held until the edge that samples ready high
    task automatic send_mode(input logic [1:0] code, input int waitn);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_data <= code;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        repeat (waitn) @(posedge ref_clk);
    endtask

    // dominant pulse from the remote node, then let the sync stages settle
    task automatic dom(input int cycles);
        node.send_dominant(cycles);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic end_test(input string name);
        repeat (2) @(posedge ref_clk);
        $display("test %s done", name);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_data = '0;
        dev_mode = DEV_NORMAL;
        link_fault_clr = 1'b0;
        bus_tx_input = 1'b1;
        restart_cnt = 2'h0;
        fails = 0;
        compares = 0;
        cyc = 0;
        void'($urandom(93884));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        note(s_mode, 2'h0);
        note(s_rx, 2'h1);
        note(s_irq, 2'h1);
        note(s_oe, 2'h0);
        note(s_fault, 2'h0);
        note(s_rdy, 2'h1);
        end_test("reset");
        // off mode: a valid wake pattern must be ignored
        dom(1100);
        note(s_rx, 2'h1);
        note(s_irq, 2'h1);
        end_test("off_wake");
        // normal and receive-only modes are refused outside Normal and Stop
        dev_mode <= DEV_SLEEP;
        send_mode(2'h3, 4);
        send_mode(2'h2, 4);
        note(s_mode, 2'h0);
        dev_mode <= DEV_NORMAL;
        end_test("refused");
        // input already dominant when enabling starts: held back until it goes high
        bus_tx_input <= 1'b0;
        send_mode(2'h3, 4);
        note(s_mode, 2'h3);
        repeat (200) @(posedge ref_clk);
        note(s_oe, 2'h0);
        bus_tx_input <= 1'b1;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            n = $urandom % 2;
            bus_tx_input <= n[0];
            repeat (8) @(posedge ref_clk);
            note(s_oe, {1'b0, ~n[0]});
            note(s_rx, {1'b0, n[0]});
        end
        bus_tx_input <= 1'b1;
        end_test("enabling");
        // stuck dominant input, then stuck dominant wire
        @(posedge ref_clk);
        bus_tx_input <= 1'b0;
        repeat (3100) @(posedge ref_clk);
        note(s_oe, 2'h0);
        note(s_fault, 2'h1);
        bus_tx_input <= 1'b1;
        repeat (8) @(posedge ref_clk);
        link_fault_clr <= 1'b1;
        @(posedge ref_clk);
        link_fault_clr <= 1'b0;
        bus_tx_input <= 1'b0;
        repeat (8) @(posedge ref_clk);
        note(s_oe, 2'h1);
        note(s_fault, 2'h0);
        note(s_mode, 2'h3);
        bus_tx_input <= 1'b1;
        dom(3100);
        note(s_fault, 2'h1);
        note(s_mode, 2'h3);
        end_test("timeouts");
        // clean enable in Stop: input kept recessive, commands queue until enabling ends
        dev_mode <= DEV_STOP;
        send_mode(2'h0, 4);
        send_mode(2'h3, 0);
        for (int i = 0; i < 4; i++) begin
            send_mode(2'h3, 0);
        end
        note(s_rdy, 2'h0);
        repeat (160) @(posedge ref_clk);
        note(s_rdy, 2'h1);
        note(s_mode, 2'h3);
        bus_tx_input <= 1'b0;
        repeat (4) @(posedge ref_clk);
        note(s_oe, 2'h1);
        bus_tx_input <= 1'b1;
        dev_mode <= DEV_NORMAL;
        end_test("clean_enable");
        // receive-only: driver stays off, wire still seen
        send_mode(2'h2, 4);
        note(s_mode, 2'h2);
        bus_tx_input <= 1'b0;
        fork
            node.send_dominant(20);
            begin
                repeat (12) @(posedge ref_clk);
                note(s_oe, 2'h0);
                note(s_rx, 2'h0);
            end
        join
        bus_tx_input <= 1'b1;
        end_test("rx_only");
        // wake in device Normal: short pulse ignored, long one wakes
        send_mode(2'h1, 4);
        note(s_mode, 2'h1);
        dom(100 + ($urandom % 800));
        note(s_rx, 2'h1);
        note(s_irq, 2'h1);
        dom(1100);
        note(s_rx, 2'h0);
        note(s_irq, 2'h0);
        note(s_mode, 2'h1);
        note(s_rst, 2'h0);
        end_test("wake_normal");
        // entering Sleep rearms, wake then requests Restart without interrupt
        dev_mode <= DEV_SLEEP;
        repeat (4) @(posedge ref_clk);
        note(s_rx, 2'h1);
        dom(1100);
        note(s_rx, 2'h0);
        note(s_irq, 2'h1);
        note(s_rst, 2'h1);
        end_test("wake_sleep");
        // rearm by toggling the mode through off
        dev_mode <= DEV_NORMAL;
        send_mode(2'h1, 4);
        dom(1100);
        note(s_rx, 2'h0);
        note(s_rst, 2'h1);
        send_mode(2'h0, 4);
        note(s_mode, 2'h0);
        note(s_rx, 2'h1);
        send_mode(2'h1, 4);
        dom(1100);
        note(s_rx, 2'h0);
        note(s_irq, 2'h0);
        end_test("rearm_toggle");
        // Fail-Safe enters wake-capable by itself; off still selectable there
        dev_mode <= DEV_FAILSAFE;
        repeat (4) @(posedge ref_clk);
        note(s_mode, 2'h1);
        note(s_rx, 2'h1);
        dom(1100);
        note(s_rst, 2'h2);
        note(s_irq, 2'h1);
        send_mode(2'h0, 4);
        note(s_mode, 2'h0);
        end_test("failsafe");
        complete_run();
    end
endmodule

`default_nettype wire
